/* File: sfh_defs.svh */
// constants of the serial flash front end: opcodes, sizes, status layout, reset values
// assumes: included by bare name wherever a design file needs one of these values
`ifndef SFH_DEFS_SVH
`define SFH_DEFS_SVH

// ----------------------------------------------------------------
// operation codes shifted in after chip select falls
// ----------------------------------------------------------------
`define SFH_OP_READ 8'h03
`define SFH_OP_DREAD 8'h3B
`define SFH_OP_QREAD 8'h6B
`define SFH_OP_PROG 8'h02
`define SFH_OP_DPROG 8'hA2
`define SFH_OP_QPROG 8'h32
`define SFH_OP_ER4K 8'h20
`define SFH_OP_ER32K 8'h52
`define SFH_OP_ER64K 8'hD8
`define SFH_OP_CHIP 8'hC7
`define SFH_OP_WREN 8'h06
`define SFH_OP_WRDI 8'h04
`define SFH_OP_PROT 8'h36
`define SFH_OP_UNPROT 8'h39
`define SFH_OP_GPROT 8'h7E
`define SFH_OP_GUNPROT 8'h98
`define SFH_OP_LOCK 8'h33
`define SFH_OP_OTPPG 8'h9B
`define SFH_OP_OTPRD 8'h77
`define SFH_OP_SUSP 8'hB0
`define SFH_OP_RESUME 8'hD0
`define SFH_OP_RDSR 8'h05
`define SFH_OP_RDID 8'h9F
`define SFH_OP_WRCFG 8'h3F

// ----------------------------------------------------------------
// operation codes handed to the array
// ----------------------------------------------------------------
`define SFH_ARR_PROG 3'h0
`define SFH_ARR_OTP 3'h1
`define SFH_ARR_ER4K 3'h2
`define SFH_ARR_ER32K 3'h3
`define SFH_ARR_ER64K 3'h4
`define SFH_ARR_CHIP 3'h5

// ----------------------------------------------------------------
// geometry, field lengths and layouts
// ----------------------------------------------------------------
`define SFH_BYTE_BITS 5'h08
`define SFH_ADDR_BITS 5'h18
`define SFH_SEC_LSB 16
`define SFH_SEC_W 6
`define SFH_SECTORS 64
`define SFH_OTP_ABITS 7
`define SFH_QE_BIT 1
`define SFH_ST_BUSY 0
`define SFH_ST_WEL 1
`define SFH_ST_WP 2
`define SFH_ST_QE 3
`define SFH_ST_SUSP 4
`define SFH_ST_FAIL 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SFH_PIN_RST 6'h10
`define SFH_PROT_RST 1'h1
`define SFH_LOCK_RST 1'h0

`endif

/* File: sfh_pkg.sv */
// types shared by the serial flash front end modules
// assumes: compiled before every module that names these types
package sfh_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b010,
    ST_DIN = 3'b011,
    ST_DOUT = 3'b100,
    ST_SKIP = 3'b101
  } sfh_state_t;

  typedef enum logic [1:0] {
    LANE_1 = 2'b00,
    LANE_2 = 2'b01,
    LANE_4 = 2'b10
  } sfh_lane_t;

  typedef enum logic [2:0] {
    CL_NONE = 3'b000,
    CL_ADDR = 3'b001,
    CL_RD = 3'b010,
    CL_PG = 3'b011,
    CL_STAT = 3'b100,
    CL_CFG = 3'b101
  } sfh_cls_t;

endpackage

/* File: sfh_stream_if.sv */
// valid/ready word stream between the front end and its program data buffer
// assumes: both ends on the same clock
`timescale 1ns/100ps
interface sfh_stream_if #(
  parameter int WIDTH = 16
) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: sfh_fifo.sv */
// program data buffer: memory of DEPTH words plus a registered output word
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/100ps
module sfh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // streams
  sfh_stream_if.snk wr,
  sfh_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("sfh_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [WIDTH-1:0] out_data;
  logic out_valid;
  logic [AW:0] next_count;

  wire push = wr.valid & wr.ready;
  wire load = (count != '0) & (~out_valid | rd.ready);

  // full only counts the memory; the output word is one extra slot
  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = out_valid;
  assign rd.data = out_data;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(load);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(load);
      count <= next_count;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (rd.ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

/* File: sfh_flash_front.sv */
// serial front end of a flash memory: frames, decodes and executes host operations
// assumes: pins are asynchronous to sys_clk, serial clock well below sys_clk / 4,
// array back end answers reads within two cycles and drains program data itself
`timescale 1ns/100ps
`include "sfh_defs.svh"
module sfh_flash_front #(
  parameter int FIFO_WIDTH = 16,
  parameter int FIFO_DEPTH = 32,
  // identification values are arbitrary
  parameter logic [7:0] MFR_ID = 8'h5A,
  parameter logic [7:0] DEV_ID0 = 8'hC3,
  parameter logic [7:0] DEV_ID1 = 8'h01
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // serial pins; io 0 data in, io 1 data out, io 2 write protect
  input wire logic sck,
  input wire logic cs_b,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic standby,
  // array operation port
  output logic arr_op_start,
  output logic [2:0] arr_op,
  output logic [23:0] arr_op_addr,
  output logic [8:0] arr_op_len,
  input wire logic arr_op_done,
  input wire logic arr_op_fail,
  output logic arr_suspend,
  // array read port
  output logic arr_rd_req,
  output logic arr_rd_otp,
  output logic [23:0] arr_rd_addr,
  input wire logic arr_rd_valid,
  input wire logic [7:0] arr_rd_data,
  // program data stream to the array
  output logic arr_wr_valid,
  output logic [FIFO_WIDTH-1:0] arr_wr_data,
  input wire logic arr_wr_ready
);
  if (FIFO_WIDTH < 16 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("sfh_flash_front needs a buffer of at least 16 bits by 2 words");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic sfh_pkg::sfh_cls_t op_class(input logic [7:0] op);
    unique case (op)
      `SFH_OP_READ, `SFH_OP_DREAD, `SFH_OP_QREAD, `SFH_OP_OTPRD: op_class = sfh_pkg::CL_RD;
      `SFH_OP_PROG, `SFH_OP_DPROG, `SFH_OP_QPROG, `SFH_OP_OTPPG: op_class = sfh_pkg::CL_PG;
      `SFH_OP_ER4K, `SFH_OP_ER32K, `SFH_OP_ER64K: op_class = sfh_pkg::CL_ADDR;
      `SFH_OP_PROT, `SFH_OP_UNPROT, `SFH_OP_LOCK: op_class = sfh_pkg::CL_ADDR;
      `SFH_OP_RDSR, `SFH_OP_RDID: op_class = sfh_pkg::CL_STAT;
      `SFH_OP_WRCFG: op_class = sfh_pkg::CL_CFG;
      default: op_class = sfh_pkg::CL_NONE;
    endcase
  endfunction

  function automatic sfh_pkg::sfh_lane_t op_lane(input logic [7:0] op);
    unique case (op)
      `SFH_OP_DREAD, `SFH_OP_DPROG: op_lane = sfh_pkg::LANE_2;
      `SFH_OP_QREAD, `SFH_OP_QPROG: op_lane = sfh_pkg::LANE_4;
      default: op_lane = sfh_pkg::LANE_1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic sck_d;
  logic cs_d;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= `SFH_PIN_RST;
      pin_s2 <= `SFH_PIN_RST;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      pin_s1 <= {sck, cs_b, io_in};
      pin_s2 <= pin_s1;
      sck_d <= pin_s2[5];
      cs_d <= pin_s2[4];
    end
  end

  wire sck_s = pin_s2[5];
  wire cs_hi = pin_s2[4];
  wire [3:0] io_s = pin_s2[3:0];
  wire sck_rise = sck_s & ~sck_d & ~cs_hi;
  wire sck_fall = ~sck_s & sck_d & ~cs_hi;
  // a frame opens only on a falling select
  wire cs_fall = ~cs_hi & cs_d;
  wire cs_rise = cs_hi & ~cs_d;

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  sfh_pkg::sfh_state_t state;
  sfh_pkg::sfh_state_t next_state;
  sfh_pkg::sfh_lane_t lane;
  logic [7:0] cmd;
  logic [4:0] cnt;
  logic [23:0] sh;
  logic [23:0] addr;
  logic [7:0] din_byte;
  logic [8:0] pg_cnt;
  logic pg_drop;
  logic busy;
  logic susp;
  logic fail;
  logic wel;
  logic qe;
  logic [`SFH_SECTORS-1:0] prot;
  logic [`SFH_SECTORS-1:0] lock;
  logic [7:0] arr_byte;
  logic [7:0] sh_out;
  logic [2:0] ocnt;
  logic [1:0] id_idx;
  logic [7:0] status_byte;
  logic [23:0] next_sh;

  wire sfh_pkg::sfh_cls_t cls = op_class(cmd);
  wire [7:0] op_new = next_sh[7:0];
  wire [4:0] step = (lane == sfh_pkg::LANE_4) ? 5'h04 : (lane == sfh_pkg::LANE_2) ? 5'h02 : 5'h01;
  wire [4:0] cnt_next = cnt + step;

  // command, address and data shift in on the rising edge
  wire rx_edge = sck_rise & (state == sfh_pkg::ST_OPC | state == sfh_pkg::ST_ADDR | state == sfh_pkg::ST_DIN);
  wire phase_end = rx_edge & (cnt_next == ((state == sfh_pkg::ST_ADDR) ? `SFH_ADDR_BITS : `SFH_BYTE_BITS));
  wire opc_end = phase_end & (state == sfh_pkg::ST_OPC);
  wire addr_end = phase_end & (state == sfh_pkg::ST_ADDR);
  wire din_end = phase_end & (state == sfh_pkg::ST_DIN);

  // one, two or four input lanes per rising edge
  // io 2 only carries data in a quad phase, reachable only with quad enable set
  always_comb begin
    unique case (lane)
      sfh_pkg::LANE_2: next_sh = {sh[21:0], io_s[1:0]};
      sfh_pkg::LANE_4: next_sh = {sh[19:0], io_s[3:0]};
      default: next_sh = {sh[22:0], io_s[0]};
    endcase
  end

  // quad operations are refused while io 2 still serves as write protect
  wire quad_bad = (op_lane(op_new) == sfh_pkg::LANE_4) & ~qe;
  wire sfh_pkg::sfh_cls_t new_cls = op_class(op_new);
  wire sfh_pkg::sfh_state_t opc_next = quad_bad ? sfh_pkg::ST_SKIP :
    (new_cls == sfh_pkg::CL_STAT) ? sfh_pkg::ST_DOUT :
    (new_cls == sfh_pkg::CL_CFG) ? sfh_pkg::ST_DIN :
    (new_cls == sfh_pkg::CL_NONE) ? sfh_pkg::ST_SKIP : sfh_pkg::ST_ADDR;
  wire sfh_pkg::sfh_state_t addr_next = (cls == sfh_pkg::CL_RD) ? sfh_pkg::ST_DOUT :
    (cls == sfh_pkg::CL_PG) ? sfh_pkg::ST_DIN : sfh_pkg::ST_SKIP;

  always_comb begin
    next_state = state;
    if (cs_hi) begin
      next_state = sfh_pkg::ST_IDLE;
    end else if (cs_fall) begin
      next_state = sfh_pkg::ST_OPC;
    end else if (opc_end) begin
      next_state = opc_next;
    end else if (addr_end) begin
      next_state = addr_next;
    end else if (din_end && cls == sfh_pkg::CL_CFG) begin
      next_state = sfh_pkg::ST_SKIP;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= sfh_pkg::ST_IDLE;
      cnt <= 5'h00;
      sh <= 24'h000000;
    end else begin
      state <= next_state;
      cnt <= (cs_fall | phase_end) ? 5'h00 : rx_edge ? cnt_next : cnt;
      sh <= rx_edge ? next_sh : sh;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd <= 8'h00;
      lane <= sfh_pkg::LANE_1;
      addr <= 24'h000000;
      din_byte <= 8'h00;
    end else begin
      if (opc_end) cmd <= op_new;
      if (cs_fall) lane <= sfh_pkg::LANE_1;
      else if (addr_end) lane <= op_lane(cmd);
      if (addr_end) addr <= next_sh;
      if (din_end) din_byte <= op_new;
    end
  end

  // ----------------------------------------------------------------
  // write permission and targets
  // ----------------------------------------------------------------
  wire [`SFH_SEC_W-1:0] sec = addr[`SFH_SEC_LSB +: `SFH_SEC_W];
  // protected sectors refuse program and erase
  // locked sectors refuse them for good
  wire sec_ok = ~prot[sec] & ~lock[sec];
  // the security area spans 128 bytes
  wire otp_ok = (addr[23:`SFH_OTP_ABITS] == '0);
  wire tgt_ok = (cmd == `SFH_OP_OTPPG) ? otp_ok : sec_ok;
  wire may_write = wel & ~busy & tgt_ok;
  // write protect low freezes protected sectors; quad enable hands the pin over
  wire wp_hi = qe | io_s[2];

  // ----------------------------------------------------------------
  // program data into the buffer
  // ----------------------------------------------------------------
  sfh_stream_if #(.WIDTH(FIFO_WIDTH)) pg_in ();
  sfh_stream_if #(.WIDTH(FIFO_WIDTH)) pg_out ();

  // at most 256 bytes accepted per operation, further bytes dropped
  wire pg_take = din_end & (cls == sfh_pkg::CL_PG) & may_write & ~pg_cnt[8];
  // low address byte wraps inside the page
  wire [7:0] pg_addr_lo = addr[7:0] + pg_cnt[7:0];

  assign pg_in.valid = pg_take;
  assign pg_in.data = FIFO_WIDTH'({pg_addr_lo, op_new});
  assign arr_wr_valid = pg_out.valid;
  assign arr_wr_data = pg_out.data;
  assign pg_out.ready = arr_wr_ready;

  sfh_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr(pg_in),
    .rd(pg_out)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_cnt <= 9'h000;
      pg_drop <= 1'b0;
    end else if (cs_fall) begin
      pg_cnt <= 9'h000;
      pg_drop <= 1'b0;
    end else if (pg_take) begin
      pg_cnt <= pg_cnt + 9'h001;
      // a byte the full buffer could not take marks the operation failed
      pg_drop <= pg_drop | ~pg_in.ready;
    end
  end

  // ----------------------------------------------------------------
  // execution when the frame closes
  // ----------------------------------------------------------------
  wire exec = cs_rise & (state == sfh_pkg::ST_SKIP | (state == sfh_pkg::ST_DIN & cls == sfh_pkg::CL_PG));
  wire is_er = (cmd == `SFH_OP_ER4K) | (cmd == `SFH_OP_ER32K) | (cmd == `SFH_OP_ER64K);
  // block erases per sector target, chip erase needs no sector held
  wire er_go = exec & is_er & may_write;
  wire chip_go = exec & (cmd == `SFH_OP_CHIP) & wel & ~busy & ~|prot & ~|lock;
  wire pg_go = exec & (cls == sfh_pkg::CL_PG) & may_write & (pg_cnt != 9'h000);
  wire op_go = er_go | chip_go | pg_go;
  wire [2:0] op_code = pg_go ? ((cmd == `SFH_OP_OTPPG) ? `SFH_ARR_OTP : `SFH_ARR_PROG) :
    chip_go ? `SFH_ARR_CHIP : (cmd == `SFH_OP_ER4K) ? `SFH_ARR_ER4K :
    (cmd == `SFH_OP_ER32K) ? `SFH_ARR_ER32K : `SFH_ARR_ER64K;
  wire keep_wel = (cmd == `SFH_OP_SUSP) | (cmd == `SFH_OP_RESUME);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arr_op_start <= 1'b0;
      arr_op <= `SFH_ARR_PROG;
      arr_op_addr <= 24'h000000;
      arr_op_len <= 9'h000;
    end else begin
      arr_op_start <= op_go;
      if (op_go) begin
        arr_op <= op_code;
        arr_op_addr <= addr;
        arr_op_len <= pg_cnt;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      susp <= 1'b0;
      fail <= 1'b0;
      wel <= 1'b0;
      qe <= 1'b0;
    end else begin
      busy <= op_go | (busy & ~arr_op_done);
      // suspend only a running operation, resume only a suspended one
      if (arr_op_done) susp <= 1'b0;
      else if (exec && cmd == `SFH_OP_SUSP && busy) susp <= 1'b1;
      else if (exec && cmd == `SFH_OP_RESUME) susp <= 1'b0;
      // failure set by the array result or at a start with dropped program data, cleared by any other start
      if (arr_op_done && arr_op_fail) fail <= 1'b1;
      else if (op_go) fail <= pg_go & pg_drop;
      if (exec) wel <= (cmd == `SFH_OP_WREN) | (wel & keep_wel);
      if (exec && cmd == `SFH_OP_WRCFG && wel) qe <= din_byte[`SFH_QE_BIT];
    end
  end

  // the array sees the suspended state as a level
  assign arr_suspend = susp;

  // one protection and one lockdown bit for each sector
  for (genvar i = 0; i < `SFH_SECTORS; i++) begin : g_sector
    wire hit = (sec == `SFH_SEC_W'(i));
    wire wr_ok = exec & wel;
    wire set_p = wr_ok & (((cmd == `SFH_OP_PROT) & hit) | (cmd == `SFH_OP_GPROT));
    // unprotect refused while write protect is low
    wire clr_p = wr_ok & wp_hi & (((cmd == `SFH_OP_UNPROT) & hit) | (cmd == `SFH_OP_GUNPROT));
    wire set_l = wr_ok & (cmd == `SFH_OP_LOCK) & hit;
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        prot[i] <= `SFH_PROT_RST;
        lock[i] <= `SFH_LOCK_RST;
      end else begin
        prot[i] <= set_p | (prot[i] & ~clr_p);
        lock[i] <= set_l | lock[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // output path
  // ----------------------------------------------------------------
  // output bits change on the falling edge
  wire tx_edge = sck_fall & (state == sfh_pkg::ST_DOUT);
  wire load_byte = tx_edge & (ocnt == 3'h0);
  wire rd_go = addr_end & (cls == sfh_pkg::CL_RD);
  wire [7:0] id_byte = (id_idx == 2'h0) ? MFR_ID : (id_idx == 2'h1) ? DEV_ID0 : DEV_ID1;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`SFH_ST_BUSY] = busy;
    status_byte[`SFH_ST_WEL] = wel;
    status_byte[`SFH_ST_WP] = wp_hi;
    status_byte[`SFH_ST_QE] = qe;
    status_byte[`SFH_ST_SUSP] = susp;
    status_byte[`SFH_ST_FAIL] = fail;
  end

  wire [7:0] src_byte = (cls == sfh_pkg::CL_RD) ? arr_byte : (cmd == `SFH_OP_RDID) ? id_byte : status_byte;
  wire [7:0] out_cur = (ocnt == 3'h0) ? src_byte : sh_out;
  // one, two or four output lanes, most significant bit first
  wire [3:0] out_bits = (lane == sfh_pkg::LANE_4) ? out_cur[7:4] :
    (lane == sfh_pkg::LANE_2) ? {2'b00, out_cur[7:6]} : {2'b00, out_cur[7], 1'b0};
  wire [3:0] out_en = (lane == sfh_pkg::LANE_4) ? 4'hF : (lane == sfh_pkg::LANE_2) ? 4'h3 : 4'h2;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      arr_rd_req <= 1'b0;
      arr_rd_otp <= 1'b0;
      arr_rd_addr <= 24'h000000;
      arr_byte <= 8'h00;
    end else begin
      // next byte is fetched while the current one shifts out
      arr_rd_req <= rd_go | (load_byte & cls == sfh_pkg::CL_RD);
      if (rd_go) arr_rd_otp <= (cmd == `SFH_OP_OTPRD);
      if (rd_go) arr_rd_addr <= next_sh;
      else if (load_byte && cls == sfh_pkg::CL_RD) arr_rd_addr <= arr_rd_addr + 24'h000001;
      if (arr_rd_valid) arr_byte <= arr_rd_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_out <= 8'h00;
      ocnt <= 3'h0;
      id_idx <= 2'h0;
    end else if (cs_fall) begin
      ocnt <= 3'h0;
      id_idx <= 2'h0;
    end else if (tx_edge) begin
      sh_out <= 8'(out_cur << step);
      ocnt <= 3'(ocnt + step);
      if (load_byte) id_idx <= (id_idx == 2'h2) ? 2'h0 : id_idx + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
      standby <= 1'b0;
    end else begin
      // outputs released as soon as the device is deselected
      if (cs_hi) begin
        io_oe <= 4'h0;
        io_out <= 4'h0;
      end else if (tx_edge) begin
        io_oe <= out_en;
        io_out <= out_bits;
      end
      // but not before the self-timed operation ends
      // busy only rises with the start, so the start itself must also hold standby off
      standby <= cs_hi & ~busy & ~op_go;
    end
  end
endmodule

/* File: sfh_sva.sv */
// checker for the flash front end, bound to its top module
// assumes: pins steady for several sys_clk between changes
`timescale 1ns/100ps
module sfh_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // pins
  input wire logic sck,
  input wire logic cs_b,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic standby,
  // array
  input wire logic arr_op_start,
  input wire logic [2:0] arr_op,
  input wire logic [8:0] arr_op_len,
  input wire logic arr_rd_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_oe_idle: assert property (cs_b [*5] |-> io_oe == 4'h0) else $error("pins driven");
  a_no_read_idle: assert property (cs_b [*5] |-> !arr_rd_req) else $error("read idle");
  a_sel_awake: assert property (!cs_b [*5] |-> !standby) else $error("standby sel");
  a_busy_awake: assert property (arr_op_start |=> !standby [*3]) else $error("standby busy");
  a_start_sleep: assert property (arr_op_start |-> !standby) else $error("standby start");
  a_start_pulse: assert property (arr_op_start |=> !arr_op_start) else $error("start len");
  a_start_at_end: assert property (arr_op_start |-> cs_b && $past(cs_b)) else $error("start sel");
  a_lane_set: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("lanes");
  a_out_on_fall: assert property (!cs_b && io_oe != 4'h0 && $changed(io_out) |-> !$past(sck)) else $error("edge");
  a_prog_len: assert property (arr_op_start && arr_op <= 3'h1 |-> arr_op_len inside {[9'h001:9'h100]})
    else $error("prog len");
  a_erase_len: assert property (arr_op_start && arr_op > 3'h1 |-> arr_op <= 3'h5 && arr_op_len == 9'h000)
    else $error("erase len");
endmodule
bind sfh_flash_front sfh_sva u_sva (.*);

/* File: sfh_host_model.sv */
// serial host model: frames operations by chip select, mode 0 or mode 3 clocking
// assumes: sys_clk 10 ns; serial clock of 80 ns made here, still outside frames
`timescale 1ns/100ps
module sfh_host_model (
  // clock
  input wire logic sys_clk,
  // pins
  output logic sck,
  output logic cs_b,
  output logic [3:0] h_io,
  input wire logic [3:0] pins
);
  logic idle_hi = 1'b0;
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    h_io = 4'hF;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // mode 3 parks the serial clock high between frames
  task automatic mode(bit m);
    idle_hi = m;
    sck <= m;
    cyc(4);
  endtask
  task automatic sel();
    cs_b <= 1'b0;
    cyc(4);
  endtask
  // released lines flip so stale levels never match
  task automatic desel();
    sck <= idle_hi;
    cyc(4);
    cs_b <= 1'b1;
    h_io <= ~h_io;
    cyc(12);
  endtask
  // fall and set, taken on the rise; clock left high between bytes
  task automatic sh(inout logic [7:0] b, input int w, input bit rd);
    for (int i = 8; i > 0; i -= w) begin
      sck <= 1'b0;
      if (!rd) h_io <= w == 1 ? {h_io[3:1], b[i-1]} : w == 2 ? {h_io[3:2], b[i-1-:2]} : b[i-1-:4];
      cyc(4);
      sck <= 1'b1;
      if (rd) b = w == 1 ? {b[6:0], pins[1]} : w == 2 ? {b[5:0], pins[1:0]} : {b[3:0], pins};
      cyc(4);
    end
  endtask
  task automatic tx(logic [7:0] v, int w);
    sh(v, w, 1'b0);
  endtask
  task automatic hdr(logic [7:0] op, logic [23:0] a, bit ad);
    sel();
    tx(op, 1);
    if (ad) for (int i = 2; i >= 0; i--) tx(a[i*8+:8], 1);
  endtask
  task automatic wen();
    hdr(8'h06, 24'h000000, 1'b0);
    desel();
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench of the flash front end with a host model and array stub
// assumes: design defaults for ids and buffer size
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sck, cs_b, standby, arr_op_start, arr_suspend, arr_rd_req, arr_rd_otp, arr_wr_valid;
  logic [3:0] h_io, io_out, io_oe;
  wire [3:0] io_in = (io_oe & io_out) | (~io_oe & h_io);
  logic [2:0] arr_op;
  logic [23:0] arr_op_addr, arr_rd_addr;
  logic [8:0] arr_op_len;
  logic [15:0] arr_wr_data, wr_word;
  logic arr_op_done = 1'b0, arr_op_fail = 1'b0, arr_rd_valid = 1'b0, arr_wr_ready = 1'b0;
  logic [7:0] arr_rd_data = 8'h00, busy_n = 8'h00, b;
  logic [35:0] got_op;
  int starts = 0, tick = 0, error_cnt = 0, comparisons = 0;
  sfh_flash_front uut (.*);
  sfh_host_model host (.sys_clk, .sck, .cs_b, .h_io, .pins(io_in));
  always #5 sys_clk = ~sys_clk;
  // array stub: slow ops, stalling program stream
  always @(posedge sys_clk) begin
    arr_rd_valid <= arr_rd_req;
    arr_rd_data <= arr_rd_addr[7:0] ^ 8'hA5;
    arr_wr_ready <= ~arr_wr_ready;
    arr_op_done <= busy_n == 8'h01;
    busy_n <= arr_op_start ? 8'hF0 : busy_n - 8'(busy_n != 8'h00);
    if (arr_wr_valid && arr_wr_ready) wr_word <= arr_wr_data;
    tick <= tick + 1;
    if (arr_op_start) begin
      starts <= starts + 1;
      got_op <= {arr_op, arr_op_len, arr_op_addr};
    end
    if (tick == 30000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(logic [39:0] got, logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_id();
    for (int m = 1; m >= 0; m--) begin
      host.mode(m[0]);
      host.hdr(8'h9F, 24'h000000, 1'b0);
      for (int i = 0; i < 4; i++) begin
        host.sh(b, 1, 1'b1);
        chk(b, i == 1 ? 8'hC3 : i == 2 ? 8'h01 : 8'h5A);
      end
      host.desel();
      chk(io_oe, 4'h0);
    end
    $display("t_id done");
  endtask
  task automatic t_read();
    logic [7:0] op [3] = '{8'h03, 8'h3B, 8'h6B};
    host.wen();
    host.hdr(8'h3F, 24'h000000, 1'b0);
    host.tx(8'h02, 1);
    host.desel();
    for (int k = 0; k < 3; k++) begin
      host.hdr(op[k], 24'h0123FE, 1'b1);
      for (int j = 0; j < 2; j++) begin
        host.sh(b, 1 << k, 1'b1);
        chk(b ^ 8'hA5, 8'hFE + j);
      end
      host.desel();
    end
    host.hdr(8'h77, 24'h000005, 1'b1);
    host.sh(b, 1, 1'b1);
    host.desel();
    chk(b ^ 8'hA5, 8'h05);
    chk(arr_rd_otp, 1'b1);
    $display("t_read done");
  endtask
  task automatic t_prog();
    host.wen();
    host.hdr(8'h98, 24'h000000, 1'b0);
    host.desel();
    for (int k = 0; k < 3; k++) begin
      host.wen();
      host.hdr(k == 0 ? 8'h02 : k == 1 ? 8'hA2 : 8'h32, 24'h000010, 1'b1);
      for (int j = 0; j <= k; j++) host.tx(8'h3C, 1 << k);
      host.desel();
      chk({standby, got_op}, {1'b0, 3'h0, 9'(k + 1), 24'h000010});
      host.cyc(250);
      chk(standby, 1'b1);
      chk(wr_word, {8'h10 + 8'(k), 8'h3C});
    end
    $display("t_prog done");
  endtask
  task automatic t_prot();
    int n;
    host.wen();
    host.hdr(8'h36, 24'h010000, 1'b1);
    host.desel();
    n = starts;
    host.wen();
    host.hdr(8'h20, 24'h010000, 1'b1);
    host.desel();
    chk(starts, n);
    arr_op_fail <= 1'b1;
    host.wen();
    host.hdr(8'hD8, 24'h020000, 1'b1);
    host.desel();
    chk(got_op, {3'h4, 9'h000, 24'h020000});
    host.hdr(8'hB0, 24'h000000, 1'b0);
    host.desel();
    chk(arr_suspend, 1'b1);
    host.hdr(8'hD0, 24'h000000, 1'b0);
    host.desel();
    chk(arr_suspend, 1'b0);
    host.cyc(80);
    arr_op_fail <= 1'b0;
    host.hdr(8'h05, 24'h000000, 1'b0);
    host.sh(b, 1, 1'b1);
    host.desel();
    chk(b[5:0], 6'h2C);
    n = starts;
    host.wen();
    host.hdr(8'h33, 24'h030000, 1'b1);
    host.desel();
    host.wen();
    host.hdr(8'h20, 24'h030000, 1'b1);
    host.desel();
    chk(starts, n);
    $display("t_prot done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    host.cyc(4);
    t_id();
    t_read();
    t_prog();
    t_prot();
    final_report();
  end
endmodule
